// ### logic/apc_pkg.sv
// package: constants, codes and helpers for the axis parameter command slave
package apc_pkg;
  // ----------------------------------------------------------------
  // clock and link timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned BAUD_RATE = 9600;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_RATE;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int unsigned FRAME_BYTES = 9;
  localparam logic [3:0] IDX_ADDR = 4'h0;
  localparam logic [3:0] IDX_CMD = 4'h1;
  localparam logic [3:0] IDX_TYPE = 4'h2;
  localparam logic [3:0] IDX_MOTOR = 4'h3;
  localparam logic [3:0] IDX_SUM = 4'h8;

  // ----------------------------------------------------------------
  // command numbers
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_SET_AXIS_PARAMETER = 8'h05;
  localparam logic [7:0] CMD_GET_AXIS_PARAMETER = 8'h06;
  localparam logic [7:0] CMD_STORE_AXIS = 8'h07;
  localparam logic [7:0] CMD_RESTORE_AXIS = 8'h08;
  localparam logic [7:0] CMD_SET_GLOBAL = 8'h09;
  localparam logic [7:0] CMD_GET_GLOBAL = 8'h0A;
  localparam logic [7:0] CMD_GET_INPUT = 8'h0F;

  // ----------------------------------------------------------------
  // status codes
  // ----------------------------------------------------------------
  localparam logic [7:0] ST_OK = 8'h64;
  localparam logic [7:0] ST_BAD_SUM = 8'h01;
  localparam logic [7:0] ST_BAD_CMD = 8'h02;
  localparam logic [7:0] ST_BAD_TYPE = 8'h03;
  localparam logic [7:0] ST_BAD_VALUE = 8'h04;
  localparam logic [7:0] ST_STORE_LOCKED = 8'h05;
  localparam logic [7:0] ST_NOT_AVAIL = 8'h06;

  // ----------------------------------------------------------------
  // axis parameter numbers, reset values and upper limits
  // ----------------------------------------------------------------
  localparam logic [7:0] AP_RUN_CURRENT = 8'h06;
  localparam logic [7:0] AP_STANDBY_CURRENT = 8'h07;
  localparam logic [7:0] AP_MICROSTEP_RESOLUTION = 8'h8C;
  localparam logic [7:0] AP_MICROSTEP_INTERPOLATION = 8'h8D;
  localparam logic [4:0] RST_RUN_CURRENT = 5'h18;
  localparam logic [4:0] RST_STANDBY_CURRENT = 5'h03;
  localparam logic [3:0] RST_MICROSTEP_RESOLUTION = 4'h4;
  localparam logic RST_MICROSTEP_INTERPOLATION = 1'b1;
  localparam logic [31:0] MAX_CURRENT = 32'h0000_001F;
  localparam logic [31:0] MAX_RESOLUTION = 32'h0000_0008;
  localparam logic [31:0] MAX_INTERPOLATION = 32'h0000_0001;

  // ----------------------------------------------------------------
  // addressing (values are arbitrary defaults)
  // ----------------------------------------------------------------
  localparam logic [7:0] DEF_MODULE_ADDR = 8'h01;
  localparam logic [7:0] DEF_REPLY_ADDR = 8'h02;

  // modulo-256 accumulate, shared by receive check and reply build
  function automatic logic [7:0] apc_sum8(input logic [7:0] acc, input logic [7:0] b);
    apc_sum8 = acc + b;
  endfunction
endpackage

// ### logic/apc_slave.sv
// axis parameter command slave: frame receiver, interpreter and reply sender
// Notes on behaviour
// R1 - run current 0..31, resets 24, used moving
// R2 - standby current 0..31, resets 3, used idle
// R3 - microstep code 0..8, 2^n steps, resets 4
// R4 - interpolation bit, 1 interpolates, resets to 1
// R5 - set command writes value to chosen parameter
// R6 - finish command actions, then send one reply
// R7 - host waits for reply before next command
// R8 - listen always; transmit only replies to commands
// R9 - host sends binary frames only
// R10 - nine bytes: address, command, type, motor, value, sum
// R11 - checksum is 8-bit sum of preceding bytes
// R12 - reply: reply addr, module addr, status, command, value, sum
// R13 - failure statuses 1..6 by error kind
// R14 - out-of-range set rejected, status invalid value
module apc_slave
  import apc_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = apc_pkg::BIT_CYCLES,
  parameter logic [7:0] MODULE_ADDR = DEF_MODULE_ADDR,
  parameter logic [7:0] REPLY_ADDR = DEF_REPLY_ADDR
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic rx_pin,
  output logic tx_pin,
  output logic tx_drive_n,
  input wire logic motor_moving,
  output logic [4:0] run_current,
  output logic [4:0] standby_current,
  output logic [3:0] microstep_resolution,
  output logic microstep_interpolation,
  output logic [4:0] active_current,
  output logic [8:0] microsteps_per_step,
  output logic reply_busy
);
  typedef enum logic [1:0] {APC_RECEIVE, APC_EXECUTE, APC_SEND, APC_WAIT} apc_state_t;

  apc_state_t state_r, state_nxt;
  logic [7:0] frame_r [0:FRAME_BYTES-1];
  logic [7:0] reply_r [0:FRAME_BYTES-2];
  logic [3:0] idx_r;
  logic [7:0] acc_r;
  logic [7:0] tx_sum_r;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic tx_start_r;
  logic [7:0] tx_byte_r;
  logic tx_busy;
  logic uart_tx;
  logic uart_drive_n;

  // ----------------------------------------------------------------
  // serial link
  // ----------------------------------------------------------------
  apc_uart #(
    .BIT_CYCLES(BIT_CYCLES)
  ) u_uart (
    .core_clk(core_clk),
    .rst(rst),
    .rx_pin(rx_pin),
    .rx_byte(rx_byte),
    .rx_valid(rx_valid),
    .tx_start(tx_start_r),
    .tx_byte(tx_byte_r),
    .tx_busy(tx_busy),
    .tx_pin(uart_tx),
    .tx_drive_n(uart_drive_n)
  );
  assign tx_pin = uart_tx; // R8
  assign tx_drive_n = uart_drive_n; // R8

  // ----------------------------------------------------------------
  // frame decode
  // ----------------------------------------------------------------
  wire [7:0] f_cmd = frame_r[IDX_CMD]; // R10
  wire [7:0] f_type = frame_r[IDX_TYPE];
  wire [7:0] f_motor = frame_r[IDX_MOTOR];
  wire [31:0] f_value = {frame_r[4], frame_r[5], frame_r[6], frame_r[7]}; // R10
  wire addr_hit = (frame_r[IDX_ADDR] == MODULE_ADDR);
  wire sum_ok = (acc_r == frame_r[IDX_SUM]); // R11
  wire is_set = (f_cmd == CMD_SET_AXIS_PARAMETER);
  wire is_get = (f_cmd == CMD_GET_AXIS_PARAMETER);
  wire is_unavail = (f_cmd == CMD_STORE_AXIS) || (f_cmd == CMD_RESTORE_AXIS) ||
                    (f_cmd == CMD_SET_GLOBAL) || (f_cmd == CMD_GET_GLOBAL) ||
                    (f_cmd == CMD_GET_INPUT);
  wire t_run = (f_type == AP_RUN_CURRENT);
  wire t_stby = (f_type == AP_STANDBY_CURRENT);
  wire t_res = (f_type == AP_MICROSTEP_RESOLUTION);
  wire t_ipol = (f_type == AP_MICROSTEP_INTERPOLATION);
  wire type_ok = t_run || t_stby || t_res || t_ipol;

  // upper limit of the selected parameter; only one axis exists
  wire [31:0] limit = (t_run || t_stby) ? MAX_CURRENT :
                      t_res ? MAX_RESOLUTION : MAX_INTERPOLATION;
  wire value_ok = (f_value <= limit) || is_get; // R14
  wire motor_ok = (f_motor == 8'h00);

  // error priority: checksum, command, type, motor/value
  wire [7:0] status = !sum_ok ? ST_BAD_SUM : // R13
                      is_unavail ? ST_NOT_AVAIL :
                      !(is_set || is_get) ? ST_BAD_CMD :
                      !type_ok ? ST_BAD_TYPE :
                      !(motor_ok && value_ok) ? ST_BAD_VALUE : ST_OK;
  wire do_write = (state_r == APC_EXECUTE) && addr_hit && is_set && (status == ST_OK); // R14

  // current value of the addressed parameter, for read-back
  wire [31:0] param_rd = t_run ? {27'h000_0000, run_current} :
                         t_stby ? {27'h000_0000, standby_current} :
                         t_res ? {28'h000_0000, microstep_resolution} :
                         {31'h0000_0000, microstep_interpolation};
  wire [31:0] reply_val = (status == ST_OK && is_get) ? param_rd : f_value;

  // ----------------------------------------------------------------
  // sequence: receive nine bytes, execute, then send nine bytes
  // ----------------------------------------------------------------
  wire last_rx = rx_valid && (idx_r == IDX_SUM);
  wire last_tx = (idx_r == IDX_SUM);
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      APC_RECEIVE: if (last_rx) state_nxt = APC_EXECUTE;
      // a frame for another address leaves the line alone
      APC_EXECUTE: state_nxt = addr_hit ? APC_SEND : APC_RECEIVE; // R8
      APC_SEND: state_nxt = APC_WAIT;
      APC_WAIT: begin
        if (!tx_busy && !tx_start_r) state_nxt = last_tx ? APC_RECEIVE : APC_SEND;
      end
      default: state_nxt = APC_RECEIVE;
    endcase
  end

  // ----------------------------------------------------------------
  // frame capture, checksum and byte index
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= APC_RECEIVE;
      idx_r <= 4'h0;
      acc_r <= 8'h00;
      for (int i = 0; i < FRAME_BYTES; i++) frame_r[i] <= 8'h00;
    end else begin
      state_r <= state_nxt;
      // bytes arriving during a reply are ignored; the host must wait
      if (state_r == APC_RECEIVE && rx_valid) begin // R7
        frame_r[idx_r] <= rx_byte; // R10
        idx_r <= last_rx ? 4'h0 : idx_r + 4'h1;
        if (idx_r == 4'h0) acc_r <= rx_byte;
        else if (!last_rx) acc_r <= apc_sum8(acc_r, rx_byte); // R11
      end else if (state_r == APC_WAIT && state_nxt == APC_SEND) begin
        idx_r <= idx_r + 4'h1;
      end else if (state_r == APC_WAIT && state_nxt == APC_RECEIVE) begin
        idx_r <= 4'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // reply build and byte hand-off; built in the same APC_EXECUTE cycle as the write below
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < FRAME_BYTES - 1; i++) reply_r[i] <= 8'h00;
      tx_sum_r <= 8'h00;
      tx_start_r <= 1'b0;
      tx_byte_r <= 8'h00;
    end else begin
      tx_start_r <= 1'b0;
      if (state_r == APC_EXECUTE) begin
        reply_r[0] <= REPLY_ADDR; // R12
        reply_r[1] <= MODULE_ADDR;
        reply_r[2] <= status; // R13
        reply_r[3] <= f_cmd;
        reply_r[4] <= reply_val[31:24]; // R12
        reply_r[5] <= reply_val[23:16];
        reply_r[6] <= reply_val[15:8];
        reply_r[7] <= reply_val[7:0];
        tx_sum_r <= 8'h00;
      end else if (state_r == APC_SEND) begin
        tx_start_r <= 1'b1; // R6
        tx_byte_r <= last_tx ? tx_sum_r : reply_r[idx_r[2:0]]; // R11
        if (!last_tx) tx_sum_r <= apc_sum8(tx_sum_r, reply_r[idx_r[2:0]]);
      end
    end
  end

  // busy flag taken from the next state, so the port comes straight from a flop
  // with the same timing as a decode of the state register would have
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reply_busy <= 1'b0;
    end else begin
      reply_busy <= (state_nxt != APC_RECEIVE);
    end
  end

  // ----------------------------------------------------------------
  // axis parameters; a rejected write leaves them as they were
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      run_current <= RST_RUN_CURRENT; // R1
      standby_current <= RST_STANDBY_CURRENT; // R2
      microstep_resolution <= RST_MICROSTEP_RESOLUTION; // R3
      microstep_interpolation <= RST_MICROSTEP_INTERPOLATION; // R4
    end else if (do_write) begin
      if (t_run) run_current <= f_value[4:0]; // R5
      if (t_stby) standby_current <= f_value[4:0]; // R5
      if (t_res) microstep_resolution <= f_value[3:0]; // R5
      if (t_ipol) microstep_interpolation <= f_value[0]; // R5
    end
  end

  // ----------------------------------------------------------------
  // derived drive settings, registered so outputs come from flops
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      active_current <= RST_STANDBY_CURRENT;
      microsteps_per_step <= 9'(9'h001 << RST_MICROSTEP_RESOLUTION);
    end else begin
      active_current <= motor_moving ? run_current : standby_current; // R1 R2
      microsteps_per_step <= 9'(9'h001 << microstep_resolution); // R3
    end
  end
endmodule // apc_slave

// ### logic/apc_uart.sv
// byte-wide serial receiver and transmitter, 8N1, one start and one stop bit
module apc_uart
  import apc_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = apc_pkg::BIT_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic rx_pin,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  input wire logic tx_start,
  input wire logic [7:0] tx_byte,
  output logic tx_busy,
  output logic tx_pin,
  output logic tx_drive_n
);
  localparam int CW = $clog2(BIT_CYCLES + 1);
  localparam logic [CW-1:0] FULL = CW'(BIT_CYCLES - 1);
  localparam logic [CW-1:0] HALF = CW'(BIT_CYCLES / 2);

  // ----------------------------------------------------------------
  // pin synchroniser and agreement filter
  // ----------------------------------------------------------------
  logic s1_r, s2_r, s3_r, rx_f_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      rx_f_r <= 1'b1;
    end else begin
      s1_r <= rx_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) rx_f_r <= s3_r; // a change counts only once two stages agree
    end
  end

  // ----------------------------------------------------------------
  // receiver: sample mid-bit, drop frames with a false start or bad stop
  // ----------------------------------------------------------------
  logic rx_busy_r;
  logic [CW-1:0] rx_cnt_r;
  logic [3:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic rx_tick;
  assign rx_tick = rx_busy_r && (rx_cnt_r == '0);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_busy_r <= 1'b0;
      rx_cnt_r <= '0;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 8'h00;
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!rx_busy_r) begin
        if (!rx_f_r) begin
          rx_busy_r <= 1'b1;
          rx_cnt_r <= HALF;
          rx_bit_r <= 4'h0;
        end
      end else if (!rx_tick) begin
        rx_cnt_r <= rx_cnt_r - 1'b1;
      end else begin
        rx_cnt_r <= FULL;
        rx_bit_r <= rx_bit_r + 4'h1;
        if (rx_bit_r == 4'h0 && rx_f_r) rx_busy_r <= 1'b0; // glitch, not a start bit
        else if (rx_bit_r == 4'h9) begin
          rx_busy_r <= 1'b0;
          rx_byte <= rx_sh_r;
          rx_valid <= rx_f_r; // framing error drops the byte silently
        end else if (rx_bit_r != 4'h0) rx_sh_r <= {rx_f_r, rx_sh_r[7:1]};
      end
    end
  end

  // ----------------------------------------------------------------
  // transmitter: line driven only while a byte is on its way
  // ----------------------------------------------------------------
  logic [CW-1:0] tx_cnt_r;
  logic [3:0] tx_bit_r;
  logic [9:0] tx_sh_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_busy <= 1'b0;
      tx_cnt_r <= '0;
      tx_bit_r <= 4'h0;
      tx_sh_r <= 10'h3FF;
      tx_pin <= 1'b1;
      tx_drive_n <= 1'b1;
    end else if (!tx_busy) begin
      tx_pin <= 1'b1;
      tx_drive_n <= 1'b1;
      if (tx_start) begin
        tx_busy <= 1'b1;
        tx_sh_r <= {1'b1, tx_byte, 1'b0};
        tx_cnt_r <= FULL;
        tx_bit_r <= 4'h0;
        tx_pin <= 1'b0;
        tx_drive_n <= 1'b0;
      end
    end else if (tx_cnt_r != '0) begin
      tx_cnt_r <= tx_cnt_r - 1'b1;
    end else begin
      tx_cnt_r <= FULL;
      tx_bit_r <= tx_bit_r + 4'h1;
      tx_sh_r <= {1'b1, tx_sh_r[9:1]};
      tx_pin <= tx_sh_r[1];
      if (tx_bit_r == 4'h9) begin
        tx_busy <= 1'b0;
        tx_pin <= 1'b1;
        tx_drive_n <= 1'b1;
      end
    end
  end
endmodule // apc_uart

// ### sim/apc_host_model.sv
// serial host model: sends binary command frames and collects the replies
module apc_host_model
  import apc_pkg::*;
#(
  parameter int unsigned BIT = 16
) (
  input wire logic core_clk,
  input wire logic tx_pin,
  input wire logic tx_drive_n,
  output logic rx_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // released device line reads high through its pull-up
  wire logic line = tx_drive_n ? 1'b1 : tx_pin;

  initial rx_pin = 1'b1;

  // one 8N1 character, lsb first, changed just after the edge
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_pin <= f[i];
      repeat (BIT) @(posedge core_clk);
    end
  endtask

  // nine-byte binary frame; a nonzero bad_sum corrupts the checksum on purpose
  task automatic send_frame(input logic [7:0] adr, input logic [7:0] cmd,
      input logic [7:0] typ, input logic [7:0] mot, input logic [31:0] val,
      input logic [7:0] bad_sum);
    logic [7:0] f [9];
    f = '{adr, cmd, typ, mot, val[31:24], val[23:16], val[15:8], val[7:0], bad_sum};
    for (int i = 0; i < 8; i++) f[8] = f[8] + f[i];
    foreach (f[i]) send_byte(f[i]);
  endtask

  // sample mid-bit; ok drops when a start bit never comes
  task automatic recv_reply(output logic [7:0] rep [9], output logic ok);
    int n;
    ok = 1'b1;
    for (int k = 0; k < 9; k++) begin
      n = 0;
      while (line === 1'b1 && n < 40 * BIT) begin
        @(posedge core_clk);
        n++;
      end
      if (n >= 40 * BIT) ok = 1'b0;
      repeat (BIT / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge core_clk);
        rep[k][i] = line;
      end
      repeat (BIT) @(posedge core_clk);
    end
  endtask
endmodule // apc_host_model

// ### sim/apc_slave_properties.sv
// checker: port-level timing and value properties of the command slave
module apc_slave_properties
  import apc_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = apc_pkg::BIT_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic rx_pin,
  input wire logic tx_pin,
  input wire logic tx_drive_n,
  input wire logic motor_moving,
  input wire logic [4:0] run_current,
  input wire logic [4:0] standby_current,
  input wire logic [3:0] microstep_resolution,
  input wire logic microstep_interpolation,
  input wire logic [4:0] active_current,
  input wire logic [8:0] microsteps_per_step,
  input wire logic reply_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // -------------------------------------------------------------
  // helper: length of each low stretch of the driver enable
  // -------------------------------------------------------------
  int unsigned low_cnt_r;
  int unsigned low_cnt_nxt;
  assign low_cnt_nxt = tx_drive_n ? 32'h0000_0000 : low_cnt_r + 32'h0000_0001;
  // counter cleared whenever the line is released
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) low_cnt_r <= 32'h0000_0000;
    else low_cnt_r <= low_cnt_nxt;
  end

  // -------------------------------------------------------------
  // sequences and properties
  // -------------------------------------------------------------
  sequence start_bit;
    !tx_pin [*8];
  endsequence
  sequence reply_begin;
    tx_drive_n ##[1:64] !tx_drive_n;
  endsequence

  idle_line_high_a: assert property (tx_drive_n |-> tx_pin)
    else $error("tx line low while released");
  drive_only_reply_a: assert property (!tx_drive_n |-> reply_busy)
    else $error("tx driven outside a reply");
  active_select_a: assert property (active_current ==
      ($past(motor_moving) ? $past(run_current) : $past(standby_current)))
    else $error("active current does not follow motion state");
  resolution_range_a: assert property (microstep_resolution <= 4'h8)
    else $error("resolution code above 8");
  steps_decode_a: assert property (microsteps_per_step ==
      (9'h001 << $past(microstep_resolution)))
    else $error("microsteps per step wrong for code");
  params_before_reply_a: assert property ($changed({run_current, standby_current,
      microstep_resolution, microstep_interpolation}) |-> reply_busy && tx_drive_n)
    else $error("parameter changed outside command execution");
  start_bit_a: assert property ($fell(tx_drive_n) |-> start_bit)
    else $error("reply byte without start bit");
  byte_length_a: assert property ($rose(tx_drive_n) |-> low_cnt_r == 10 * BIT_CYCLES)
    else $error("reply byte not ten bit times");
  stop_bit_a: assert property ($rose(tx_drive_n) |-> $past(tx_pin))
    else $error("reply byte without stop bit");
  // a frame for another address raises busy for a single cycle and gets no reply
  reply_prompt_a: assert property ($rose(reply_busy) ##1 reply_busy |-> reply_begin)
    else $error("reply did not start after frame");
endmodule // apc_slave_properties

// ### sim/apc_slave_tb.sv
// testbench: command table through the host model, then fault and reset cases
module apc_slave_tb import apc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // short bit time keeps the run small
  localparam int unsigned BITC = 16;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] typ;
    logic [7:0] mot;
    logic [31:0] val;
    logic [7:0] st;
    logic [31:0] rv;
  } apc_row_t;
  // command, type, motor, value -> status, reply value
  localparam apc_row_t ROWS [17] = '{
    '{8'h05, 8'h06, 8'h00, 32'h0000_001F, 8'h64, 32'h0000_001F},
    '{8'h05, 8'h06, 8'h00, 32'h0000_0020, 8'h04, 32'h0000_0020},
    '{8'h05, 8'h07, 8'h00, 32'h0000_0000, 8'h64, 32'h0000_0000},
    '{8'h05, 8'h07, 8'h00, 32'h8000_0001, 8'h04, 32'h8000_0001},
    '{8'h05, 8'h8C, 8'h00, 32'h0000_0008, 8'h64, 32'h0000_0008},
    '{8'h05, 8'h8C, 8'h00, 32'h0000_0009, 8'h04, 32'h0000_0009},
    '{8'h05, 8'h8D, 8'h00, 32'h0000_0000, 8'h64, 32'h0000_0000},
    '{8'h05, 8'h8D, 8'h00, 32'h0000_0002, 8'h04, 32'h0000_0002},
    '{8'h05, 8'h06, 8'h01, 32'h0000_0001, 8'h04, 32'h0000_0001},
    '{8'h05, 8'h01, 8'h00, 32'h0000_0001, 8'h03, 32'h0000_0001},
    '{8'h06, 8'h8C, 8'h00, 32'h0000_0000, 8'h64, 32'h0000_0008},
    '{8'h03, 8'h06, 8'h00, 32'h0000_0000, 8'h02, 32'h0000_0000},
    '{8'h07, 8'h06, 8'h00, 32'h0000_0000, 8'h06, 32'h0000_0000},
    '{8'h08, 8'h06, 8'h00, 32'h0000_0000, 8'h06, 32'h0000_0000},
    '{8'h09, 8'h06, 8'h00, 32'h0000_0000, 8'h06, 32'h0000_0000},
    '{8'h0A, 8'h06, 8'h00, 32'h0000_0000, 8'h06, 32'h0000_0000},
    '{8'h0F, 8'h06, 8'h00, 32'h0000_0000, 8'h06, 32'h0000_0000}};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic motor_moving = 1'b0;
  logic rx_pin;
  logic tx_pin;
  logic tx_drive_n;
  logic [4:0] run_current;
  logic [4:0] standby_current;
  logic [3:0] microstep_resolution;
  logic microstep_interpolation;
  logic [4:0] active_current;
  logic [8:0] microsteps_per_step;
  logic reply_busy;
  logic quiet_bad;
  logic [7:0] rep [9];
  logic [4:0] e_run = RST_RUN_CURRENT;
  logic [4:0] e_stby = RST_STANDBY_CURRENT;
  logic [3:0] e_res = RST_MICROSTEP_RESOLUTION;
  logic e_int = RST_MICROSTEP_INTERPOLATION;
  int num_errors = 0;
  int tests_run = 0;

  always #5 core_clk = ~core_clk;

  apc_slave #(.BIT_CYCLES(BITC)) dut_u (.core_clk(core_clk), .rst(rst), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .tx_drive_n(tx_drive_n), .motor_moving(motor_moving),
    .run_current(run_current), .standby_current(standby_current),
    .microstep_resolution(microstep_resolution),
    .microstep_interpolation(microstep_interpolation), .active_current(active_current),
    .microsteps_per_step(microsteps_per_step), .reply_busy(reply_busy));
  apc_host_model #(.BIT(BITC)) host_u (.core_clk(core_clk), .tx_pin(tx_pin),
    .tx_drive_n(tx_drive_n), .rx_pin(rx_pin));

  // -------------------------------------------------------------
  // checking helpers
  // -------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk_params();
    chk(run_current, e_run);
    chk(standby_current, e_stby);
    chk(microstep_resolution, e_res);
    chk(microstep_interpolation, e_int);
    chk(microsteps_per_step, 9'h001 << e_res);
  endtask

  // one command, then the whole reply before anything else goes out
  task automatic run_cmd(input apc_row_t r, input logic [7:0] bad);
    logic ok;
    logic [7:0] e [9];
    host_u.send_frame(DEF_MODULE_ADDR, r.cmd, r.typ, r.mot, r.val, bad);
    host_u.recv_reply(rep, ok);
    if (ok !== 1'b1) begin
      num_errors++;
      tally_and_finish();
    end else begin
      e = '{DEF_REPLY_ADDR, DEF_MODULE_ADDR, r.st, r.cmd, r.rv[31:24], r.rv[23:16],
        r.rv[15:8], r.rv[7:0], 8'h00};
      for (int i = 0; i < 8; i++) e[8] = e[8] + e[i];
      for (int i = 0; i < 9; i++) chk(rep[i], e[i]);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk_params();
    chk({tx_drive_n, reply_busy, active_current}, {2'b10, e_stby});
    foreach (ROWS[i]) begin
      run_cmd(ROWS[i], 8'h00);
      if (ROWS[i].st === ST_OK && ROWS[i].cmd === CMD_SET_AXIS_PARAMETER) begin
        case (ROWS[i].typ)
          AP_RUN_CURRENT: e_run = ROWS[i].val[4:0];
          AP_STANDBY_CURRENT: e_stby = ROWS[i].val[4:0];
          AP_MICROSTEP_RESOLUTION: e_res = ROWS[i].val[3:0];
          default: e_int = ROWS[i].val[0];
        endcase
      end
      chk_params();
    end
    // corrupted checksum is answered but changes nothing
    run_cmd('{8'h05, 8'h06, 8'h00, 32'h0000_0005, 8'h01, 32'h0000_0005}, 8'h01);
    chk_params();
    // frame for another address: line must stay released
    host_u.send_frame(8'h03, 8'h05, 8'h06, 8'h00, 32'h0000_0005, 8'h00);
    quiet_bad = 1'b0;
    repeat (30 * BITC) begin
      @(posedge core_clk);
      if (tx_drive_n !== 1'b1 || reply_busy !== 1'b0) quiet_bad = 1'b1;
    end
    chk(quiet_bad, 1'b0);
    chk_params();
    // motion state picks the current in use
    motor_moving <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk(active_current, e_run);
    motor_moving <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(active_current, e_stby);
    // reset in mid-run brings back the defaults
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    e_run = RST_RUN_CURRENT;
    e_stby = RST_STANDBY_CURRENT;
    e_res = RST_MICROSTEP_RESOLUTION;
    e_int = RST_MICROSTEP_INTERPOLATION;
    repeat (2) @(posedge core_clk);
    chk_params();
    tally_and_finish();
  end
endmodule // apc_slave_tb

bind apc_slave apc_slave_properties #(.BIT_CYCLES(BIT_CYCLES)) prop_u (.core_clk(core_clk),
  .rst(rst), .rx_pin(rx_pin), .tx_pin(tx_pin), .tx_drive_n(tx_drive_n),
  .motor_moving(motor_moving), .run_current(run_current), .standby_current(standby_current),
  .microstep_resolution(microstep_resolution),
  .microstep_interpolation(microstep_interpolation), .active_current(active_current),
  .microsteps_per_step(microsteps_per_step), .reply_busy(reply_busy));
